// *** verilog/cfu_pkg.sv ***
// Function
// - The five flags error, carry, greater, equal and less live in bits 3 to 7 of special word 255.
// - An instruction that tracks the error flag sets it on bad operand data and clears it otherwise.
// - Arithmetic and shift instructions that affect carry load it from their carry or shifted-out bit.
// - A comparison sets greater, less or equal according to how the value stands against the reference.
// - Arithmetic instructions that affect the equal flag set it on a zero result and clear it otherwise.
// - Every flag an instruction affects is written on and off from its result, but bad operand data or a set error flag leaves all but error alone.
// - With the error flag set, ladder, timer and counter instructions run but other error-tracking ones are skipped.
// - With the error flag set, carry, greater, equal and less change only on the end-of-program instruction.
// - Coded instructions outside the flag table, other than codes 01, 40 and 41, leave all five flags alone.
// - The differentiated form of an instruction treats the flags exactly like its plain form.
// - The end-of-program instruction, code 01, clears all five flags.
// - The set-carry instruction, code 40, forces carry on and touches no other flag.
// - The clear-carry instruction, code 41, forces carry off and touches no other flag.
// - The compare instruction, code 20, updates error, greater, equal and less but not carry.
// - The add instruction, code 30, updates error, carry and equal but not greater or less.
package cfu_pkg;

   // function codes are two bcd digits, as written in the program
   localparam logic [7:0] FC_END       = 8'h01;
   localparam logic [7:0] FC_COMPARE   = 8'h20;
   localparam logic [7:0] FC_ADD       = 8'h30;
   localparam logic [7:0] FC_SET_CARRY = 8'h40;
   localparam logic [7:0] FC_CLR_CARRY = 8'h41;

   // flag positions within special word 255
   localparam int FLAG_ERR_BIT = 3;
   localparam int FLAG_CY_BIT  = 4;
   localparam int FLAG_GR_BIT  = 5;
   localparam int FLAG_EQ_BIT  = 6;
   localparam int FLAG_LE_BIT  = 7;

   // register byte offsets
   localparam logic [7:0] ADDR_FLAGS    = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
   localparam logic [7:0] ADDR_SKIP_CNT = 8'h0C;
   localparam logic [7:0] ADDR_LAST_FC  = 8'h10;

   // interrupt event bits
   localparam int IRQ_ERR_RISE = 0;
   localparam int IRQ_SKIP     = 1;
   localparam int IRQ_END      = 2;
   localparam int IRQ_W        = 3;

   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
   localparam logic [15:0]      SKIP_CNT_RST = 16'h0000;
   localparam logic [7:0]       LAST_FC_RST  = 8'h00;

   typedef struct packed {
      logic le;
      logic eq;
      logic gr;
      logic cy;
      logic er;
   } cfu_flags_t;

   localparam cfu_flags_t FLAGS_RST = 5'h00;

   typedef struct packed {
      logic       valid;
      logic [7:0] funcCode;
      logic       ladder;
      logic       timer;
      logic       counter;
      logic       differentiated;
   } cfu_instr_t;

   typedef struct packed {
      logic operandErr;
      logic carryOut;
      logic resultZero;
      logic cmpGreater;
      logic cmpEqual;
      logic cmpLess;
   } cfu_result_t;

endpackage

// *** verilog/cfu_flag_update.sv ***
`timescale 1ns/1ps
module cfu_flag_update (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic [31:0]              hrdata,
   output logic                     hresp,
   input  wire cfu_pkg::cfu_instr_t  instr,
   input  wire cfu_pkg::cfu_result_t result,
   output logic                     execEnable,
   output logic [7:0]               flagWord,
   output logic                     irq
);
   import cfu_pkg::*;

   cfu_flags_t       flags_r;
   cfu_flags_t       flags_nxt;
   cfu_flags_t       affect;
   logic             exempt;
   logic             isEnd;
   logic             isSetCy;
   logic             isClrCy;
   logic             skip;
   logic             okToUpdate;
   logic [IRQ_W-1:0] irqStat_r;
   logic [IRQ_W-1:0] irqMask_r;
   logic [IRQ_W-1:0] events;
   logic [15:0]      skipCnt_r;
   logic [7:0]       lastFc_r;
   logic             wrPend_r;
   logic [7:0]       wrAddr_r;
   logic             addrPhase;
   logic [IRQ_W-1:0] w1c;

   // which flags a coded instruction may write
   function automatic cfu_flags_t decode(input logic [7:0] fc);
      cfu_flags_t m;
      m = 5'h00;
      case (fc)
         8'h12, 8'h15, 8'h16,
         8'h60, 8'h61, 8'h62, 8'h63, 8'h64,
         8'h69, 8'h70, 8'h71, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77,
         8'h82, 8'h83, 8'h86, 8'h91,
         8'h46, 8'h47: begin
            m.er = 1'b1;
         end
         FC_COMPARE: begin
            m.er = 1'b1;
            m.gr = 1'b1;
            m.eq = 1'b1;
            m.le = 1'b1;
         end
         8'h21, 8'h22, 8'h23, 8'h24,
         8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39,
         8'h52, 8'h53,
         8'h65, 8'h66, 8'h67, 8'h68: begin
            m.er = 1'b1;
            m.eq = 1'b1;
         end
         8'h25, 8'h26, 8'h27, 8'h28,
         FC_ADD, 8'h31, 8'h50, 8'h51: begin
            m.er = 1'b1;
            m.cy = 1'b1;
            m.eq = 1'b1;
         end
         8'h29: begin
            m.er = 1'b1;
            m.eq = 1'b1;
            m.le = 1'b1;
         end
         8'h84: begin
            m.er = 1'b1;
            m.cy = 1'b1;
         end
         default: begin
            m = 5'h00;
         end
      endcase
      return m;
   endfunction

   // differentiated bit takes no part in flag handling
   always_comb begin
      exempt  = instr.ladder | instr.timer | instr.counter;
      isEnd   = ~exempt & (instr.funcCode == FC_END);
      isSetCy = ~exempt & (instr.funcCode == FC_SET_CARRY);
      isClrCy = ~exempt & (instr.funcCode == FC_CLR_CARRY);
      if (instr.ladder) begin
         affect = 5'h00;
      end else if (instr.timer | instr.counter) begin
         affect    = 5'h00;
         affect.er = 1'b1;
      end else begin
         affect = decode(instr.funcCode);
      end
   end

   // pending error blocks error-tracking instructions, except ladder/timer/counter
   assign skip       = instr.valid & flags_r.er & affect.er & ~exempt;
   assign execEnable = instr.valid & ~skip;
   // apart from the end-of-program clear, no flag besides error moves while error is set or just raised
   assign okToUpdate = ~flags_r.er & ~(affect.er & result.operandErr);

   always_comb begin
      flags_nxt = flags_r;
      if (instr.valid) begin
         if (isEnd) begin
            flags_nxt = FLAGS_RST;
         end else if (!skip) begin
            if (affect.er) begin
               flags_nxt.er = result.operandErr;
            end
            if (okToUpdate) begin
               if (isSetCy) begin
                  flags_nxt.cy = 1'b1;
               end
               if (isClrCy) begin
                  flags_nxt.cy = 1'b0;
               end
               if (affect.cy) begin
                  flags_nxt.cy = result.carryOut;
               end
               if (affect.gr) begin
                  flags_nxt.gr = result.cmpGreater;
               end
               if (affect.le) begin
                  flags_nxt.le = result.cmpLess;
               end
               if (affect.eq) begin
                  if (instr.funcCode == FC_COMPARE) begin
                     flags_nxt.eq = result.cmpEqual;
                  end else begin
                     flags_nxt.eq = result.resultZero;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flags_r <= FLAGS_RST;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   always_comb begin
      flagWord               = 8'h00;
      flagWord[FLAG_ERR_BIT] = flags_r.er;
      flagWord[FLAG_CY_BIT]  = flags_r.cy;
      flagWord[FLAG_GR_BIT]  = flags_r.gr;
      flagWord[FLAG_EQ_BIT]  = flags_r.eq;
      flagWord[FLAG_LE_BIT]  = flags_r.le;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         skipCnt_r <= SKIP_CNT_RST;
         lastFc_r  <= LAST_FC_RST;
      end else begin
         if (skip) begin
            // wraps; software takes differences
            skipCnt_r <= skipCnt_r + 16'h0001;
         end
         if (execEnable & ~exempt) begin
            lastFc_r <= instr.funcCode;
         end
      end
   end

   // bus: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addrPhase = hsel & htrans[1] & hready;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h00;
      end else begin
         wrPend_r <= addrPhase & hwrite;
         wrAddr_r <= haddr[7:0];
      end
   end

   // read data latched at address phase so it stands through the data phase
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (addrPhase & ~hwrite) begin
         case (haddr[7:0])
            ADDR_FLAGS:    hrdata <= {24'h00_0000, flagWord};
            ADDR_IRQ_STAT: hrdata <= {29'h0000_0000, irqStat_r};
            ADDR_IRQ_MASK: hrdata <= {29'h0000_0000, irqMask_r};
            ADDR_SKIP_CNT: hrdata <= {16'h0000, skipCnt_r};
            ADDR_LAST_FC:  hrdata <= {24'h00_0000, lastFc_r};
            default:       hrdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqMask_r <= IRQ_MASK_RST;
      end else if (wrPend_r && wrAddr_r == ADDR_IRQ_MASK) begin
         irqMask_r <= hwdata[IRQ_W-1:0];
      end
   end

   always_comb begin
      events               = '0;
      events[IRQ_ERR_RISE] = ~flags_r.er & flags_nxt.er;
      events[IRQ_SKIP]     = skip;
      events[IRQ_END]      = instr.valid & isEnd;
   end

   assign w1c = (wrPend_r && wrAddr_r == ADDR_IRQ_STAT) ? hwdata[IRQ_W-1:0] : '0;

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqStat_r <= '0;
      end else begin
         irqStat_r <= (irqStat_r & ~w1c) | events;
      end
   end

   assign irq = |(irqStat_r & irqMask_r);

endmodule // cfu_flag_update

// *** dv/cfu_seq_model.sv ***
`timescale 1ns/1ps
module cfu_seq_model (
   input  wire logic          clk,
   output cfu_pkg::cfu_instr_t  instr,
   output cfu_pkg::cfu_result_t result,
   input  wire logic          execEnable
);
   import cfu_pkg::*;
   initial begin
      instr = '0;
      result = '0;
   end
   task automatic issue(input cfu_instr_t i, input cfu_result_t r, output logic en);
      instr <= i;
      result <= r;
      #1 en = execEnable;
      @(posedge clk);
      // one edge per instruction; a held valid would execute it again
      instr <= '0;
      #1;
   endtask
   // scrambled result while idle so stale data never looks valid
   task automatic idle();
      instr <= '0;
      result <= ~result;
      @(posedge clk);
      #1;
   endtask
endmodule // cfu_seq_model

// *** dv/cfu_flag_update_sva.sv ***
`timescale 1ns/1ps
module cfu_flag_update_sva (
   input wire logic                 clk,
   input wire logic                 sys_rst,
   input wire cfu_pkg::cfu_instr_t  instr,
   input wire cfu_pkg::cfu_result_t result,
   input wire logic                 execEnable,
   input wire logic [7:0]           flagWord
);
   import cfu_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic go;
   logic [7:0] fc;
   assign go = instr.valid && !(instr.ladder | instr.timer | instr.counter);
   assign fc = instr.funcCode;
   a_end_clears: assert property (go && fc == FC_END |=> flagWord == 8'h00)
      else $error("end left flags set");
   a_setc_only: assert property (go && fc == FC_SET_CARRY && !flagWord[3]
      |=> flagWord[4] && $stable(flagWord[3]) && $stable(flagWord[7:5])) else $error("set carry wrong");
   a_clrc_only: assert property (go && fc == FC_CLR_CARRY && !flagWord[3]
      |=> !flagWord[4] && $stable(flagWord[3]) && $stable(flagWord[7:5])) else $error("clear carry wrong");
   a_cmp_keeps_cy: assert property (go && fc == FC_COMPARE |=> $stable(flagWord[4]))
      else $error("compare changed carry");
   a_add_keeps_grle: assert property (go && fc == FC_ADD |=> $stable(flagWord[5]) && $stable(flagWord[7]))
      else $error("add changed greater or less");
   a_cmp_result: assert property (go && fc == FC_COMPARE && !flagWord[3] && !result.operandErr
      |=> flagWord[7:5] == {$past(result.cmpLess), $past(result.cmpEqual), $past(result.cmpGreater)})
      else $error("compare flags wrong");
   a_add_result: assert property (go && fc == FC_ADD && !flagWord[3] && !result.operandErr
      |=> flagWord[6] == $past(result.resultZero) && flagWord[4] == $past(result.carryOut))
      else $error("add flags wrong");
   a_skip_blocks: assert property (go && flagWord[3] && (fc == FC_COMPARE || fc == FC_ADD) |-> !execEnable)
      else $error("instruction not skipped");
   a_err_freezes: assert property (flagWord[3] && !(go && fc == FC_END) |=> $stable(flagWord[7:4]))
      else $error("flags moved under error");
   a_idle_holds: assert property (!instr.valid |=> $stable(flagWord))
      else $error("flags moved while idle");
endmodule // cfu_flag_update_sva
bind cfu_flag_update cfu_flag_update_sva chkr (.clk(clk), .sys_rst(sys_rst), .instr(instr), .result(result),
   .execEnable(execEnable), .flagWord(flagWord));

// *** dv/cfu_flag_update_tb.sv ***
`timescale 1ns/1ps
module cfu_flag_update_tb;
   import cfu_pkg::*;
   logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, execEnable, irq, en;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [31:0] seed = 32'h0226787C;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] flagWord;
   logic [4:0] expF;
   cfu_instr_t instr;
   cfu_result_t result;
   int miscompares, samples_checked, cycles, expSkip;
   cfu_flag_update dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .instr(instr), .result(result), .execEnable(execEnable),
      .flagWord(flagWord), .irq(irq));
   cfu_seq_model seq (.clk(clk), .instr(instr), .result(result), .execEnable(execEnable));
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles > 5000) begin
         miscompares++;
         report_and_stop();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // f holds {less, equal, greater, carry, error}
   function automatic logic [4:0] nxt(input logic [4:0] f, input cfu_instr_t i, input cfu_result_t r);
      if (i.timer | i.counter)
         f[0] = r.operandErr;
      else if (i.funcCode == FC_END)
         f = '0;
      else if (i.funcCode == FC_COMPARE && !f[0]) begin
         f[0] = r.operandErr;
         if (!r.operandErr) f[4:2] = {r.cmpLess, r.cmpEqual, r.cmpGreater};
      end else if (i.funcCode == FC_ADD && !f[0]) begin
         f[0] = r.operandErr;
         if (!r.operandErr) {f[3], f[1]} = {r.resultZero, r.carryOut};
      end else if ((i.funcCode == FC_SET_CARRY || i.funcCode == FC_CLR_CARRY) && !f[0])
         f[1] = (i.funcCode == FC_SET_CARRY);
      return f;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk); while (!hreadyout);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (!hreadyout);
      r = hrdata;
      chk("resp", 32'h0, {31'h0, hresp});
   endtask
   task automatic run(input cfu_instr_t i, input cfu_result_t r);
      logic e;
      e = !(expF[0] && !(i.timer | i.counter) && (i.funcCode == FC_COMPARE || i.funcCode == FC_ADD));
      seq.issue(i, r, en);
      chk("exec", {31'h0, e}, {31'h0, en});
      if (!e) expSkip++;
      expF = nxt(expF, i, r);
      chk("flags", {24'h0, expF, 3'h0}, {24'h0, flagWord});
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      cfu_instr_t i;
      cfu_result_t r;
      logic [7:0] codes [6] = '{FC_END, FC_COMPARE, FC_ADD, FC_SET_CARRY, FC_CLR_CARRY, 8'h99};
      {hsel, hwrite, haddr, htrans, hwdata, expF} = '0;
      hsize = 3'h2;
      sys_rst = 1;
      repeat (3) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      ahb(0, ADDR_IRQ_MASK, 32'h0, q);
      chk("mask rst", 32'h0, q);
      for (int n = 0; n < 300; n++) begin
         q = rnd();
         i = '0;
         i.valid = 1;
         i.funcCode = codes[q % 6];
         i.timer = q[3] & q[4];
         i.counter = q[3] & !q[4] & q[5];
         i.ladder = !q[3] & q[4] & q[5];
         if (i.timer | i.counter | i.ladder) i.funcCode = 8'h00;
         i.differentiated = q[7];
         r = q[13:8];
         r.operandErr = q[8] & q[9] & q[10];
         run(i, r);
         if (q[31:29] == 0) seq.idle();
      end
      chk("irq masked", 32'h0, {31'h0, irq});
      $display("test random done");
      i = '0;
      i.valid = 1;
      r = '0;
      run(i, r);
      ahb(1, ADDR_IRQ_STAT, 32'h7, q);
      ahb(1, ADDR_IRQ_MASK, 32'h2, q);
      i.funcCode = FC_ADD;
      r.operandErr = 1;
      run(i, r);
      chk("irq off", 32'h0, {31'h0, irq});
      r = '0;
      r.carryOut = 1;
      run(i, r);
      chk("irq on", 32'h1, {31'h0, irq});
      ahb(0, ADDR_IRQ_STAT, 32'h0, q);
      chk("irq stat", 32'h3, q);
      ahb(0, ADDR_FLAGS, 32'h0, q);
      chk("flag reg", {24'h0, expF, 3'h0}, q);
      ahb(0, 8'h14, 32'h0, q);
      chk("unmapped", 32'h0, q);
      ahb(1, ADDR_IRQ_STAT, 32'h7, q);
      #1;
      chk("irq clr", 32'h0, {31'h0, irq});
      i.funcCode = FC_END;
      run(i, r);
      ahb(0, ADDR_SKIP_CNT, 32'h0, q);
      chk("skip cnt", expSkip, q);
      ahb(0, ADDR_LAST_FC, 32'h0, q);
      chk("last fc", 32'h1, q);
      ahb(0, ADDR_IRQ_STAT, 32'h0, q);
      chk("end stat", 32'h4, q);
      $display("test irq done");
      report_and_stop();
   end
endmodule // cfu_flag_update_tb
